// *** dv/ppio_bench.sv ***
// Purpose: self-checking bench for the parallel io block
// Assumes: avalon bus with waitrequest, pins resolved by ppio_periph
// Notes:   expected values come from the control word layout
`timescale 1ns/100ps
module ppio_bench;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [2:0] address = 3'h0;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [31:0] writedata = 32'h00000000;
    logic [3:0] byteenable = 4'hf;
    logic [31:0] readdata;
    logic waitrequest;
    ppio_pkg::ppio_pins_t pinIn;
    ppio_pkg::ppio_pins_t pinOut;
    ppio_pkg::ppio_pins_t pinOe;
    ppio_pkg::ppio_pins_t ext = ppio_pkg::PINS_ZERO;
    int badCount = 0;
    int cmpCount = 0;
    logic [31:0] rd;
    logic [7:0] cExp;
    logic [23:0] oeExp;
    logic [7:0] pv [3] = '{8'h3c, 8'hc3, 8'h5a};

    always #20 clk = ~clk;

    ppio_top i_dut (.clk(clk), .rst_b(rst_b), .address(address),
        .read(read), .write(write), .writedata(writedata),
        .byteenable(byteenable), .readdata(readdata),
        .waitrequest(waitrequest), .pinIn(pinIn), .pinOut(pinOut),
        .pinOe(pinOe));
    ppio_periph i_periph (.pinOut(pinOut), .pinOe(pinOe), .ext(ext),
        .pinIn(pinIn));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [31:0] seen,
        input logic [31:0] exp);
        cmpCount++;
        if (seen !== exp) begin
            badCount++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // one access; held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [2:0] a,
        input logic [7:0] d, input logic [3:0] be);
        int n;
        n = 0;
        @(posedge clk);
        address <= a;
        writedata <= {24'h000000, d};
        byteenable <= be;
        read <= ~wr;
        write <= wr;
        do begin
            @(posedge clk);
            n++;
        end while (waitrequest !== 1'b0 && n < 50);
        if (n >= 50) badCount++;
        rd = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask : bus

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        bus(1'b1, a, d, 4'hf);
    endtask : wr

    task automatic rdchk(input logic [2:0] a, input logic [7:0] e);
        bus(1'b0, a, 8'h00, 4'hf);
        check("readback", rd, {24'h000000, e});
    endtask : rdchk

    task automatic idle(input int n);
        repeat (n) @(posedge clk);
    endtask : idle

    task automatic conclude;
        $display("comparisons %0d mismatches %0d", cmpCount, badCount);
        if (badCount == 0 && cmpCount > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : conclude

    // ------------------------------------------------------------
    // watchdog
    // ------------------------------------------------------------
    initial begin
        repeat (5000) @(posedge clk);
        badCount++;
        conclude();
    end

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        idle(3);
        check("oe reset", {8'h00, pinOe}, 32'h00000000);
        check("out reset", {8'h00, pinOut}, 32'h00000000);
        check("wait reset", {31'h0, waitrequest}, 32'h1);
        check("rdata reset", readdata, 32'h00000000);
        ext <= '{a: pv[0], b: pv[1], c: pv[2]};
        idle(5);
        for (int k = 0; k < 3; k++) begin
            rdchk(3'(k), pv[k]);
        end
        $display("test reset done");

        for (int i = 0; i < 16; i++) begin
            wr(ppio_pkg::IDX_CTL, {3'h4, i[3], i[2], 1'b0, i[1], i[0]});
            idle(4);
            oeExp = {i[3] ? 8'h00 : 8'hff, i[1] ? 8'h00 : 8'hff,
                i[2] ? 4'h0 : 4'hf, i[0] ? 4'h0 : 4'hf};
            check("direction", {8'h00, pinOe}, {8'h00, oeExp});
        end
        $display("test directions done");

        wr(ppio_pkg::IDX_CTL, 8'h80);
        wr(ppio_pkg::IDX_PA, 8'ha5);
        wr(ppio_pkg::IDX_PB, 8'h3c);
        wr(ppio_pkg::IDX_PC, 8'hf0);
        idle(4);
        check("out all", {8'h00, pinOut}, 32'h00a53cf0);
        rdchk(ppio_pkg::IDX_PA, 8'ha5);
        wr(ppio_pkg::IDX_CTL, 8'h90);
        idle(4);
        check("mix oe", {8'h00, pinOe}, 32'h0000ffff);
        rdchk(ppio_pkg::IDX_PA, pv[0]);
        $display("test basic done");

        wr(ppio_pkg::IDX_CTL, 8'h80);
        wr(ppio_pkg::IDX_PB, 8'h3c);
        cExp = 8'h00;
        for (int n = 0; n < 8; n++) begin
            wr(ppio_pkg::IDX_CTL, {4'h0, 3'(n), 1'b1});
            cExp = cExp | (8'h01 << n);
            idle(4);
            check("bit set", {24'h000000, pinOut.c}, {24'h0, cExp});
        end
        wr(ppio_pkg::IDX_CTL, 8'h06);
        idle(4);
        check("bit clear", {24'h000000, pinOut.c}, 32'h000000f7);
        rdchk(ppio_pkg::IDX_PB, 8'h3c);
        $display("test bit set done");

        bus(1'b1, ppio_pkg::IDX_PB, 8'hff, 4'h0);
        rdchk(ppio_pkg::IDX_PB, 8'h3c);
        wr(3'h5, 8'hff);
        rdchk(3'h5, 8'h00);
        rdchk(3'h7, 8'h00);
        $display("test refusals done");

        ext.c <= 8'h50;
        wr(ppio_pkg::IDX_CTL, 8'hb0);
        wr(ppio_pkg::IDX_CTL, 8'h09);
        @(posedge clk);
        ext.a <= 8'h5a;
        @(posedge clk);
        ext.c[4] <= 1'b0;
        idle(2);
        ext.c[4] <= 1'b1;
        idle(6);
        ext.a <= 8'h00;
        check("in full", {30'h0, pinOe.c[5], pinOut.c[5]}, 32'h3);
        check("in intr", {31'h0, pinOut.c[3]}, 32'h1);
        rdchk(ppio_pkg::IDX_PA, 8'h5a);
        idle(3);
        check("in clear", {30'h0, pinOut.c[5], pinOut.c[3]}, 32'h0);
        $display("test strobed done");

        wr(ppio_pkg::IDX_CTL, 8'hc0);
        wr(ppio_pkg::IDX_PA, 8'h96);
        wr(ppio_pkg::IDX_PB, 8'h81);
        idle(4);
        check("obf low", {30'h0, pinOe.c[7], pinOut.c[7]}, 32'h2);
        check("a held", {24'h0, pinOe.a}, 32'h00000000);
        check("b out", {16'h0, pinOe.b, pinOut.b}, 32'h0000ff81);
        @(posedge clk);
        ext.c[6] <= 1'b0;
        idle(6);
        check("a driven", {16'h0, pinOe.a, pinOut.a}, 32'h0000ff96);
        check("obf high", {31'h0, pinOut.c[7]}, 32'h1);
        ext.c[6] <= 1'b1;
        idle(6);
        check("a free", {24'h0, pinOe.a}, 32'h00000000);
        $display("test bidir done");

        // port b strobed input while port a stays bidirectional
        ext.c <= 8'h54;
        wr(ppio_pkg::IDX_CTL, 8'hc7);
        wr(ppio_pkg::IDX_CTL, 8'h05);
        ext.b <= 8'h69;
        @(posedge clk);
        ext.c[2] <= 1'b0;
        idle(2);
        ext.c[2] <= 1'b1;
        idle(6);
        check("b full", {30'h0, pinOe.c[1], pinOut.c[1]}, 32'h3);
        check("b intr", {31'h0, pinOut.c[0]}, 32'h1);
        rdchk(ppio_pkg::IDX_PB, 8'h69);
        idle(3);
        check("b clear", {30'h0, pinOut.c[1], pinOut.c[0]}, 32'h0);

        // port b strobed output, acknowledge on the shared line
        wr(ppio_pkg::IDX_CTL, 8'hc5);
        wr(ppio_pkg::IDX_CTL, 8'h05);
        wr(ppio_pkg::IDX_PB, 8'h42);
        idle(4);
        check("b obf", {29'h0, pinOe.c[1], pinOut.c[1], pinOut.c[0]},
            32'h4);
        check("b drive", {16'h0, pinOe.b, pinOut.b}, 32'h0000ff42);
        @(posedge clk);
        ext.c[2] <= 1'b0;
        idle(6);
        check("b ack", {30'h0, pinOut.c[1], pinOut.c[0]}, 32'h3);
        ext.c[2] <= 1'b1;
        idle(2);
        $display("test port b done");

        // port a strobed output with its interrupt enabled
        wr(ppio_pkg::IDX_CTL, 8'ha0);
        wr(ppio_pkg::IDX_CTL, 8'h0d);
        wr(ppio_pkg::IDX_PA, 8'h77);
        idle(4);
        check("a obf", {29'h0, pinOe.c[7], pinOut.c[7], pinOut.c[3]},
            32'h4);
        check("a drive", {16'h0, pinOe.a, pinOut.a}, 32'h0000ff77);
        @(posedge clk);
        ext.c[6] <= 1'b0;
        idle(6);
        check("a ack", {30'h0, pinOut.c[7], pinOut.c[3]}, 32'h3);
        ext.c[6] <= 1'b1;
        idle(2);
        $display("test strobed out done");
        conclude();
    end
endmodule : ppio_bench

// *** dv/ppio_periph.sv ***
// Purpose: peripheral side of the 24 pins, resolving each wire
// Assumes: the peripheral drives every line the block leaves free
// Notes:   no pull resistors, so a free line shows the bench level
`timescale 1ns/100ps
module ppio_periph (
    input wire ppio_pkg::ppio_pins_t pinOut, // block drive values
    input wire ppio_pkg::ppio_pins_t pinOe, // block drive enables
    input wire ppio_pkg::ppio_pins_t ext, // peripheral levels
    output ppio_pkg::ppio_pins_t pinIn // resolved wire levels
);
    // the block wins wherever it drives; the peripheral elsewhere
    assign pinIn = (pinOut & pinOe) | (ext & ~pinOe);
endmodule : ppio_periph

// *** rtl/ppio_pkg.sv ***
// Purpose: shared constants and types of the programmable peripheral io
// Assumes: 8-bit ports, registers one per 32-bit Avalon word
// Notes:   word index = Avalon word address
package ppio_pkg;
    // ------------------------------------------------------------
    // register map (word index)
    // ------------------------------------------------------------
    localparam int ADDR_W = 3;
    localparam logic [2:0] IDX_PA = 3'h0;
    localparam logic [2:0] IDX_PB = 3'h1;
    localparam logic [2:0] IDX_PC = 3'h2;
    localparam logic [2:0] IDX_CTL = 3'h3;
    localparam logic [23:0] PAD_ZERO = 24'h000000;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [31:0] WORD_ZERO = 32'h00000000;

    // ------------------------------------------------------------
    // control word fields
    // ------------------------------------------------------------
    localparam int CTL_MSET = 7;
    localparam int CTL_ABIDIR = 6;
    localparam int CTL_ASTRB = 5;
    localparam int CTL_AIN = 4;
    localparam int CTL_CUIN = 3;
    localparam int CTL_BSTRB = 2;
    localparam int CTL_BIN = 1;
    localparam int CTL_CLIN = 0;
    localparam int BSR_SEL_HI = 3;
    localparam int BSR_SEL_LO = 1;
    localparam int BSR_VAL = 0;

    // ------------------------------------------------------------
    // port c handshake line positions
    // ------------------------------------------------------------
    localparam int PC_INTRB = 0;
    localparam int PC_FLAGB = 1;
    localparam int PC_STBB = 2;
    localparam int PC_INTRA = 3;
    localparam int PC_STBA = 4;
    localparam int PC_IBFA = 5;
    localparam int PC_ACKA = 6;
    localparam int PC_OBFA = 7;

    typedef enum logic [1:0] {
        MODE_BASIC,
        MODE_STROBED,
        MODE_BIDIR
    } ppio_amode_t;

    typedef struct packed {
        ppio_amode_t modeA;
        logic aIn;
        logic cuIn;
        logic bStrobed;
        logic bIn;
        logic clIn;
    } ppio_cfg_t;

    typedef struct packed {
        logic [7:0] a;
        logic [7:0] b;
        logic [7:0] c;
    } ppio_pins_t;

    localparam ppio_cfg_t CFG_RESET = '{modeA: MODE_BASIC, aIn: 1'b1,
        cuIn: 1'b1, bStrobed: 1'b0, bIn: 1'b1, clIn: 1'b1};
    localparam ppio_pins_t PINS_ZERO = '{a: 8'h00, b: 8'h00, c: 8'h00};
endpackage : ppio_pkg

// *** rtl/ppio_top.sv ***
// Purpose: three-port parallel io with basic, strobed and bidir modes
// Assumes: Avalon-MM slave, one wait state per access, byte lane 0 only
// Notes:   pin inputs pass a two-stage synchroniser before use
//
// Design decisions made here: the register offsets and register access over Avalon-MM.
`timescale 1ns/100ps

module ppio_top (
    input wire logic clk, // 25 MHz system clock
    input wire logic rst_b, // async reset, active low
    input wire logic [ppio_pkg::ADDR_W-1:0] address, // word address
    input wire logic read, // avalon read
    input wire logic write, // avalon write
    input wire logic [31:0] writedata, // avalon write data
    input wire logic [3:0] byteenable, // avalon byte enables
    output logic [31:0] readdata, // avalon read data
    output logic waitrequest, // avalon wait
    input wire ppio_pkg::ppio_pins_t pinIn, // pin levels
    output ppio_pkg::ppio_pins_t pinOut, // pin drive values
    output ppio_pkg::ppio_pins_t pinOe // pin drive enables
);
    // ------------------------------------------------------------
    // reset and input synchronisers
    // ------------------------------------------------------------
    logic [1:0] rstSync_ff;
    logic rstSync_b;
    ppio_pkg::ppio_pins_t pinMeta_ff;
    ppio_pkg::ppio_pins_t pins;
    ppio_pkg::ppio_pins_t prevC_ff;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rstSync_ff <= 2'h0;
        end else begin
            rstSync_ff <= {rstSync_ff[0], 1'b1};
        end
    end
    assign rstSync_b = rstSync_ff[1];

    always_ff @(posedge clk or negedge rstSync_b) begin
        if (!rstSync_b) begin
            pinMeta_ff <= ppio_pkg::PINS_ZERO;
            pins <= ppio_pkg::PINS_ZERO;
            prevC_ff <= ppio_pkg::PINS_ZERO;
        end else begin
            pinMeta_ff <= pinIn;
            pins <= pinMeta_ff;
            prevC_ff <= pins;
        end
    end

    // ------------------------------------------------------------
    // avalon slave
    // ------------------------------------------------------------
    logic waitReq_ff;
    logic req;
    logic setup;
    logic wrAcc;
    logic rdAcc;
    logic [7:0] wrByte;
    logic [7:0] rdMux;
    logic [31:0] readdata_ff;

    assign req = read | write;
    assign setup = req & waitReq_ff;
    assign wrAcc = write & ~waitReq_ff & byteenable[0];
    assign rdAcc = read & ~waitReq_ff;
    assign wrByte = writedata[7:0];

    // one wait state lets read data come from a register
    always_ff @(posedge clk or negedge rstSync_b) begin
        if (!rstSync_b) begin
            waitReq_ff <= 1'b1;
        end else begin
            waitReq_ff <= ~setup;
        end
    end

    always_ff @(posedge clk or negedge rstSync_b) begin
        if (!rstSync_b) begin
            readdata_ff <= ppio_pkg::WORD_ZERO;
        end else if (setup) begin
            readdata_ff <= {ppio_pkg::PAD_ZERO, rdMux};
        end
    end
    assign readdata = readdata_ff;
    assign waitrequest = waitReq_ff;

    // ------------------------------------------------------------
    // configuration and output latches
    // ------------------------------------------------------------
    ppio_pkg::ppio_cfg_t cfg_ff;
    logic [7:0] outA_ff;
    logic [7:0] outB_ff;
    logic [7:0] outC_ff;
    logic ctlWr;
    logic modeSet;
    logic [2:0] bsrSel;

    assign ctlWr = wrAcc && address == ppio_pkg::IDX_CTL;
    assign modeSet = ctlWr && wrByte[ppio_pkg::CTL_MSET];
    assign bsrSel = wrByte[ppio_pkg::BSR_SEL_HI:ppio_pkg::BSR_SEL_LO];

    always_ff @(posedge clk or negedge rstSync_b) begin
        if (!rstSync_b) begin
            cfg_ff <= ppio_pkg::CFG_RESET;
        end else if (modeSet) begin
            // group a and group b fields decode separately
            cfg_ff.modeA <= wrByte[ppio_pkg::CTL_ABIDIR] ?
                ppio_pkg::MODE_BIDIR : (wrByte[ppio_pkg::CTL_ASTRB] ?
                ppio_pkg::MODE_STROBED : ppio_pkg::MODE_BASIC);
            cfg_ff.aIn <= wrByte[ppio_pkg::CTL_AIN];
            cfg_ff.cuIn <= wrByte[ppio_pkg::CTL_CUIN];
            cfg_ff.bStrobed <= wrByte[ppio_pkg::CTL_BSTRB];
            cfg_ff.bIn <= wrByte[ppio_pkg::CTL_BIN];
            cfg_ff.clIn <= wrByte[ppio_pkg::CTL_CLIN];
        end
    end

    // a mode change clears the latches so nothing stale is driven
    always_ff @(posedge clk or negedge rstSync_b) begin
        if (!rstSync_b) begin
            outA_ff <= ppio_pkg::BYTE_ZERO;
            outB_ff <= ppio_pkg::BYTE_ZERO;
            outC_ff <= ppio_pkg::BYTE_ZERO;
        end else if (modeSet) begin
            outA_ff <= ppio_pkg::BYTE_ZERO;
            outB_ff <= ppio_pkg::BYTE_ZERO;
            outC_ff <= ppio_pkg::BYTE_ZERO;
        end else if (ctlWr) begin
            outC_ff[bsrSel] <= wrByte[ppio_pkg::BSR_VAL];
        end else if (wrAcc) begin
            case (address)
                ppio_pkg::IDX_PA: outA_ff <= wrByte;
                ppio_pkg::IDX_PB: outB_ff <= wrByte;
                ppio_pkg::IDX_PC: outC_ff <= wrByte;
                default: outC_ff <= outC_ff;
            endcase
        end
    end

    // ------------------------------------------------------------
    // handshake flags
    // ------------------------------------------------------------
    logic aStrobed;
    logic aBidir;
    logic aHsIn;
    logic aHsOut;
    logic bHsIn;
    logic bHsOut;
    logic fallStbA;
    logic fallAckA;
    logic fallStbB;
    logic wrPA;
    logic wrPB;
    logic rdPA;
    logic rdPB;
    logic ibfA_ff;
    logic obfA_ff;
    logic ibfB_ff;
    logic obfB_ff;
    logic [7:0] inA_ff;
    logic [7:0] inB_ff;
    logic intrA;
    logic intrB;

    assign aStrobed = cfg_ff.modeA == ppio_pkg::MODE_STROBED;
    assign aBidir = cfg_ff.modeA == ppio_pkg::MODE_BIDIR;
    assign aHsIn = (aStrobed && cfg_ff.aIn) || aBidir;
    assign aHsOut = (aStrobed && !cfg_ff.aIn) || aBidir;
    assign bHsIn = cfg_ff.bStrobed && cfg_ff.bIn;
    assign bHsOut = cfg_ff.bStrobed && !cfg_ff.bIn;
    assign fallStbA = prevC_ff.c[ppio_pkg::PC_STBA] &
        ~pins.c[ppio_pkg::PC_STBA];
    assign fallAckA = prevC_ff.c[ppio_pkg::PC_ACKA] &
        ~pins.c[ppio_pkg::PC_ACKA];
    assign fallStbB = prevC_ff.c[ppio_pkg::PC_STBB] &
        ~pins.c[ppio_pkg::PC_STBB];
    assign wrPA = wrAcc && address == ppio_pkg::IDX_PA;
    assign wrPB = wrAcc && address == ppio_pkg::IDX_PB;
    assign rdPA = rdAcc && address == ppio_pkg::IDX_PA;
    assign rdPB = rdAcc && address == ppio_pkg::IDX_PB;

    // strobe or write wins over a clear in the same cycle
    always_ff @(posedge clk or negedge rstSync_b) begin
        if (!rstSync_b) begin
            ibfA_ff <= 1'b0;
            obfA_ff <= 1'b0;
            inA_ff <= ppio_pkg::BYTE_ZERO;
        end else if (modeSet) begin
            ibfA_ff <= 1'b0;
            obfA_ff <= 1'b0;
        end else begin
            if (aHsIn && fallStbA) begin
                ibfA_ff <= 1'b1;
                inA_ff <= pins.a;
            end else if (rdPA) begin
                ibfA_ff <= 1'b0;
            end
            if (aHsOut && wrPA) begin
                obfA_ff <= 1'b1;
            end else if (aHsOut && fallAckA) begin
                obfA_ff <= 1'b0;
            end
        end
    end

    // port b strobe shares its line with acknowledge
    always_ff @(posedge clk or negedge rstSync_b) begin
        if (!rstSync_b) begin
            ibfB_ff <= 1'b0;
            obfB_ff <= 1'b0;
            inB_ff <= ppio_pkg::BYTE_ZERO;
        end else if (modeSet) begin
            ibfB_ff <= 1'b0;
            obfB_ff <= 1'b0;
        end else begin
            if (bHsIn && fallStbB) begin
                ibfB_ff <= 1'b1;
                inB_ff <= pins.b;
            end else if (rdPB) begin
                ibfB_ff <= 1'b0;
            end
            if (bHsOut && wrPB) begin
                obfB_ff <= 1'b1;
            end else if (bHsOut && fallStbB) begin
                obfB_ff <= 1'b0;
            end
        end
    end

    // interrupt enables live in the port c latch bits
    assign intrA = (aHsIn && outC_ff[ppio_pkg::PC_STBA] && ibfA_ff) ||
        (aHsOut && outC_ff[ppio_pkg::PC_ACKA] && !obfA_ff);
    assign intrB = (bHsIn && outC_ff[ppio_pkg::PC_STBB] && ibfB_ff) ||
        (bHsOut && outC_ff[ppio_pkg::PC_STBB] && !obfB_ff);

    // ------------------------------------------------------------
    // pin drive
    // ------------------------------------------------------------
    ppio_pkg::ppio_pins_t nxt_pinOut;
    ppio_pkg::ppio_pins_t nxt_pinOe;
    ppio_pkg::ppio_pins_t pinOut_ff;
    ppio_pkg::ppio_pins_t pinOe_ff;

    always_comb begin
        nxt_pinOut.a = outA_ff;
        nxt_pinOut.b = outB_ff;
        nxt_pinOut.c = outC_ff;
        // bidir port a drives only while acknowledge is held low
        nxt_pinOe.a = {8{aBidir ? ~pins.c[ppio_pkg::PC_ACKA] :
            ~cfg_ff.aIn}};
        nxt_pinOe.b = {8{~cfg_ff.bIn}};
        nxt_pinOe.c = {{4{~cfg_ff.cuIn}}, {4{~cfg_ff.clIn}}};
        if (aHsIn) begin
            nxt_pinOe.c[ppio_pkg::PC_STBA] = 1'b0;
            nxt_pinOe.c[ppio_pkg::PC_IBFA] = 1'b1;
            nxt_pinOut.c[ppio_pkg::PC_IBFA] = ibfA_ff;
        end
        if (aHsOut) begin
            nxt_pinOe.c[ppio_pkg::PC_ACKA] = 1'b0;
            nxt_pinOe.c[ppio_pkg::PC_OBFA] = 1'b1;
            nxt_pinOut.c[ppio_pkg::PC_OBFA] = ~obfA_ff;
        end
        if (aStrobed || aBidir) begin
            nxt_pinOe.c[ppio_pkg::PC_INTRA] = 1'b1;
            nxt_pinOut.c[ppio_pkg::PC_INTRA] = intrA;
        end
        if (cfg_ff.bStrobed) begin
            nxt_pinOe.c[ppio_pkg::PC_STBB] = 1'b0;
            nxt_pinOe.c[ppio_pkg::PC_FLAGB] = 1'b1;
            nxt_pinOe.c[ppio_pkg::PC_INTRB] = 1'b1;
            nxt_pinOut.c[ppio_pkg::PC_FLAGB] = cfg_ff.bIn ? ibfB_ff :
                ~obfB_ff;
            nxt_pinOut.c[ppio_pkg::PC_INTRB] = intrB;
        end
    end

    always_ff @(posedge clk or negedge rstSync_b) begin
        if (!rstSync_b) begin
            pinOut_ff <= ppio_pkg::PINS_ZERO;
            pinOe_ff <= ppio_pkg::PINS_ZERO;
        end else begin
            pinOut_ff <= nxt_pinOut;
            pinOe_ff <= nxt_pinOe;
        end
    end
    assign pinOut = pinOut_ff;
    assign pinOe = pinOe_ff;

    // ------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------
    always_comb begin
        case (address)
            ppio_pkg::IDX_PA: begin
                if (aHsIn) begin
                    rdMux = inA_ff;
                end else begin
                    rdMux = cfg_ff.aIn ? pins.a : outA_ff;
                end
            end
            ppio_pkg::IDX_PB: begin
                if (bHsIn) begin
                    rdMux = inB_ff;
                end else begin
                    rdMux = cfg_ff.bIn ? pins.b : outB_ff;
                end
            end
            ppio_pkg::IDX_PC: begin
                rdMux = (nxt_pinOut.c & nxt_pinOe.c) |
                    (pins.c & ~nxt_pinOe.c);
            end
            default: rdMux = ppio_pkg::BYTE_ZERO;
        endcase
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstSync_b);

    sequence strobeB_s;
        bHsIn && fallStbB;
    endsequence

    sequence flagB_s;
        ibfB_ff ##1 pinOut_ff.c[ppio_pkg::PC_FLAGB];
    endsequence

    reset_all_inputs_a: assert property (
        (cfg_ff == ppio_pkg::CFG_RESET &&
        $past(cfg_ff) == ppio_pkg::CFG_RESET) |->
        pinOe_ff == ppio_pkg::PINS_ZERO)
        else $error("line driven while configured as input");
    wait_one_a: assert property (
        (req && waitrequest) |=> !waitrequest)
        else $error("request not acknowledged after one wait");
    ack_single_a: assert property (
        !waitrequest |=> waitrequest)
        else $error("acknowledge longer than one cycle");
    out_hold_a: assert property (
        (wrPA && !aBidir) |-> ##2 pinOut_ff.a == $past(wrByte, 2))
        else $error("port a output not from written value");
    bit_setreset_a: assert property (
        (ctlWr && !wrByte[ppio_pkg::CTL_MSET]) |=>
        outC_ff[$past(bsrSel)] == $past(wrByte[ppio_pkg::BSR_VAL]))
        else $error("single bit write lost");
    input_direct_a: assert property (
        (setup && address == ppio_pkg::IDX_PA && cfg_ff.aIn && !aHsIn)
        |=> readdata_ff[7:0] == $past(pins.a))
        else $error("input read not pin level");
    out_readback_a: assert property (
        (setup && address == ppio_pkg::IDX_PB && !cfg_ff.bIn)
        |=> readdata_ff[7:0] == $past(outB_ff))
        else $error("output read not latch value");
    strobe_flag_a: assert property (
        strobeB_s |=> flagB_s)
        else $error("port b strobe did not raise full flag");
    ack_clears_a: assert property (
        (aHsOut && fallAckA && !wrPA && !modeSet) |=> !obfA_ff)
        else $error("acknowledge did not empty port a");
    bidir_b_free_a: assert property (
        (aBidir && !cfg_ff.bIn && $past(aBidir && !cfg_ff.bIn)) |->
        pinOe_ff.b == 8'hff)
        else $error("port b output lost in bidir mode");
endmodule : ppio_top
